// ==== verilog/gcsr_cfg.svh ====
// Constants of the global configuration and status register group.
// Assumes inclusion by bare name from the package and the top module.
`ifndef GCSR_CFG_SVH
`define GCSR_CFG_SVH

// Serial frame layout
`define GCSR_FRAME_BITS   6'h28
`define GCSR_CNT_W        6
`define GCSR_SHIFT_W      40
`define GCSR_DATA_W       32
`define GCSR_IDX_W        7
`define GCSR_WR_BIT       39
`define GCSR_IDX_HI       38
`define GCSR_IDX_LO       32

// Register indices, write adds the top address bit
`define GCSR_REG_GCONF    7'h00
`define GCSR_REG_GLOBAL_STATUS    7'h01
`define GCSR_REG_TESTSEL  7'h03
`define GCSR_REG_INPUT    7'h04
`define GCSR_REG_XCMP     7'h05

// Configuration fields
`define GCSR_GCONF_W      11
`define GCSR_GC_POSCMP    3
`define GCSR_GC_TESTMODE  7
`define GCSR_GC_INVA      8
`define GCSR_GC_INVB      9
`define GCSR_GC_LOCK      10

// Status fields
`define GCSR_GLOBAL_STATUS_W      4
`define GCSR_GS_RESET     0
`define GCSR_GS_DRVA      1
`define GCSR_GS_DRVB      2
`define GCSR_GS_UV        3
`define GCSR_GLOBAL_STATUS_RST    4'h1

// Test selector and readback fields
`define GCSR_TESTSEL_W    4
`define GCSR_IN_ENN_BIT   7
`define GCSR_REV_W        8
`define GCSR_STAT_PAD     4'h0

`endif

// ==== verilog/gcsr_pkg.sv ====
// Types of the global configuration and status register group.
// Assumes gcsr_cfg.svh is on the include path.
`default_nettype none
`include "gcsr_cfg.svh"

package gcsr_pkg;

	// Serial frame sequencer, one-hot
	typedef enum logic [2:0] {
		GCSR_IDLE   = 3'h1,
		GCSR_SHIFT  = 3'h2,
		GCSR_COMMIT = 3'h4
	} gcsr_state_t;

	// Whole state of the top module except the synchroniser stages
	typedef struct packed {
		gcsr_state_t                  state;
		logic                         sckPrev;
		logic                         csnPrev;
		logic [`GCSR_CNT_W-1:0]       bitCnt;
		logic [`GCSR_SHIFT_W-1:0]     rxShift;
		logic [`GCSR_SHIFT_W-1:0]     txShift;
		logic [`GCSR_DATA_W-1:0]      readData;
		logic [`GCSR_GCONF_W-1:0]     gconf;
		logic [`GCSR_GLOBAL_STATUS_W-1:0]     global_status;
		logic [`GCSR_TESTSEL_W-1:0]   testSel;
		logic [`GCSR_DATA_W-1:0]      compare;
		logic                         pulse;
		logic                         intLvl;
		logic                         dirA;
		logic                         dirB;
		logic                         drvDisable;
		logic                         sdoOe;
	} gcsr_regs_t;

endpackage

`default_nettype wire

// ==== verilog/gcsr_sync.sv ====
// Two-stage synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to clk; idle level of all is high.
`timescale 1ns/100ps
`default_nettype none

module gcsr_sync #(
	parameter int WIDTH = 4
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Raw pins and synchronised copy
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] pinSync
);

	// Both stages in one state word
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} gcsr_sync_t;

	gcsr_sync_t syncState_r;    // Registered stages
	gcsr_sync_t syncState_nxt;  // Next stages

	// First stage feeds only the second
	always_comb begin
		syncState_nxt.meta   = pinIn;
		syncState_nxt.stable = syncState_r.meta;
	end

	// Reset to idle-high so no false edge at release
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			syncState_r <= '1;
		end else begin
			syncState_r <= syncState_nxt;
		end
	end

	assign pinSync = syncState_r.stable;

endmodule // gcsr_sync

`default_nettype wire

// ==== verilog/gcsr_regs_top.sv ====
// Global configuration and status registers behind the serial port.
// Assumes a 40-bit frame, MSB first, sampled on rising sck.
// Assumes sck and csn are slow against clk (several clk per half).
// Assumes protection and motion inputs come from this clock.
// Assumes read results return in the frame after the read.
// Limitation: a frame cut short is dropped without trace.
// Limitation: sck and sdi share sync lag, so setup holds.
`timescale 1ns/100ps
`default_nettype none
`include "gcsr_cfg.svh"

module gcsr_regs_top #(
	// Revision code, value arbitrary
	// Kept as a parameter so a respin only changes it
	parameter logic [`GCSR_REV_W-1:0] REVISION_CODE = 8'h5A
) (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    rst_n,

	// Serial register port pins
	input  wire logic                    sckPin,
	input  wire logic                    csnPin_n,
	input  wire logic                    sdiPin,
	output logic                         sdoOut,
	output logic                         sdoOe,

	// Driver enable pin, active low
	input  wire logic                    driver_enable_n_pin,

	// Motion core, same clock
	input  wire logic [`GCSR_DATA_W-1:0] actual_position,
	input  wire logic                    intRequest,
	input  wire logic                    motorADirCmd,
	input  wire logic                    motorBDirCmd,

	// Driver protection, same clock
	input  wire logic                    driverAOverTemp,
	input  wire logic                    driverAShort,
	input  wire logic                    driverBOverTemp,
	input  wire logic                    driverBShort,
	input  wire logic                    pumpUndervoltage,

	// Position pulse and interrupt pins
	output logic                         position_pulse_out,
	output logic                         positionPulseOe,
	output logic                         intOut,
	output logic                         intOe,

	// Motor direction and driver gate
	output logic                         motorADirOut,
	output logic                         motorBDirOut,
	output logic                         driversDisable,

	// Analog test routing
	output logic                         refTestEnable,
	output logic [`GCSR_TESTSEL_W-1:0]   testSignalSelect
);

	// Synchronised pins
	// Only these copies are read; raw pins never are
	logic [3:0] pinSync;              // All four pins after two flops
	logic       sckS;                 // Serial clock
	logic       csnS;                 // Chip select, low active
	logic       sdiS;                 // Serial data in
	logic       ennS;                 // Driver enable pin level

	// State word
	// One packed word holds every flop of the block except the synchroniser stages
	gcsr_pkg::gcsr_regs_t regs_r;     // Registered state
	gcsr_pkg::gcsr_regs_t regs_nxt;   // Next state

	// Decoded events
	// All combinational, valid in the cycle they are seen
	logic sckRise;                    // Sample edge
	logic sckFall;                    // Shift-out edge
	logic csnFall;                    // Frame start
	logic csnRise;                    // Frame end
	logic clrStat;                    // Status read this cycle
	logic drvAErr;                    // Any driver A error
	logic drvBErr;                    // Any driver B error
	logic [`GCSR_IDX_W-1:0] regIdx;   // Addressed register
	logic [`GCSR_DATA_W-1:0] wrData;  // Written word

	// Pins cross into clk domain here
	// All four share one lag, so sck and sdi stay aligned
	// Three clk per edge seen; sets the shortest host half
	gcsr_sync #(
		.WIDTH (4)
	) u_sync (
		.clk     (clk),
		.rst_n   (rst_n),
		.pinIn   ({sckPin, csnPin_n, sdiPin, driver_enable_n_pin}),
		.pinSync (pinSync)
	);

	assign sckS = pinSync[3];
	assign csnS = pinSync[2];
	assign sdiS = pinSync[1];
	assign ennS = pinSync[0];

	// Rising edge of a sampled level
	// Both inputs already synchronised
	function automatic logic edgeRise(input logic prev, input logic cur);
		edgeRise = cur & ~prev;
	endfunction

	// Falling edge of a sampled level
	// Both inputs already synchronised
	function automatic logic edgeFall(input logic prev, input logic cur);
		edgeFall = prev & ~cur;
	endfunction

	// Read multiplexer; write-only and unmapped read zero
	// Status is taken as it stands at the commit cycle
	function automatic logic [`GCSR_DATA_W-1:0] readMux(
		input logic [`GCSR_IDX_W-1:0] idx,
		input gcsr_pkg::gcsr_regs_t   st,
		input logic                   enn
	);
		logic [`GCSR_DATA_W-1:0] v;
		v = '0;
		case (idx)
			`GCSR_REG_GCONF: begin
				v[`GCSR_GCONF_W-1:0] = st.gconf;
			end
			`GCSR_REG_GLOBAL_STATUS: begin
				v[`GCSR_GLOBAL_STATUS_W-1:0] = st.global_status;
			end
			`GCSR_REG_INPUT: begin
				// Low bits carry nothing; host ignores them
				v[`GCSR_IN_ENN_BIT] = enn;
				v[`GCSR_DATA_W-1 -: `GCSR_REV_W] = REVISION_CODE;
			end
			default: begin
				v = '0;
			end
		endcase
		readMux = v;
	endfunction

	// Sticky flag update; a set beats the clearing read
	// Shared by all four status bits so they age alike
	function automatic logic stickyNext(
		input logic setEv,
		input logic cur,
		input logic clr
	);
		stickyNext = setEv | (cur & ~clr);
	endfunction

	// Edge decode against previous sample
	// Prev flops reset high, matching idle pins
	assign sckRise = edgeRise(regs_r.sckPrev, sckS);
	assign sckFall = edgeFall(regs_r.sckPrev, sckS);
	assign csnFall = edgeFall(regs_r.csnPrev, csnS);
	assign csnRise = edgeRise(regs_r.csnPrev, csnS);

	// Frame fields
	// Valid only in COMMIT, after all 40 bits are in
	assign regIdx = regs_r.rxShift[`GCSR_IDX_HI:`GCSR_IDX_LO];
	assign wrData = regs_r.rxShift[`GCSR_DATA_W-1:0];

	// Error summaries per driver
	// Either cause latches the same status flag
	assign drvAErr = driverAOverTemp | driverAShort;
	assign drvBErr = driverBOverTemp | driverBShort;

	// Next-state logic for the whole block
	// One copy of the state word, filled from the old one
	// Defaults hold everything; branches change only their fields
	always_comb begin
		regs_nxt = regs_r;
		clrStat  = 1'b0;

		// Edge history
		// Sampled every clk, in every state
		regs_nxt.sckPrev = sckS;
		regs_nxt.csnPrev = csnS;

		// Serial frame sequencer
		// Idle waits, shift collects bits, commit acts once
		case (regs_r.state)
			gcsr_pkg::GCSR_IDLE: begin
				// Wait for select; sck activity alone is ignored
				if (csnFall) begin
					// Status byte first, then last read result
					regs_nxt.txShift = {`GCSR_STAT_PAD, regs_r.global_status,
						regs_r.readData};
					regs_nxt.bitCnt  = '0;
					regs_nxt.state   = gcsr_pkg::GCSR_SHIFT;
				end
			end
			gcsr_pkg::GCSR_SHIFT: begin
				// Select release ends the frame at any count
				if (csnRise) begin
					// Short frames are dropped whole
					if (regs_r.bitCnt == `GCSR_FRAME_BITS) begin
						regs_nxt.state = gcsr_pkg::GCSR_COMMIT;
					end else begin
						regs_nxt.state = gcsr_pkg::GCSR_IDLE;
					end
				end else begin
					if (sckRise) begin
						// Long frames keep their last 40 bits
						regs_nxt.rxShift = {regs_r.rxShift[`GCSR_SHIFT_W-2:0], sdiS};
						// Bit count saturates at a full frame
						if (regs_r.bitCnt != `GCSR_FRAME_BITS) begin
							regs_nxt.bitCnt = regs_r.bitCnt + 6'h01;
						end
					end
					// Idle-high sck gives a fall before any rise
					if (sckFall && regs_r.bitCnt != '0) begin
						regs_nxt.txShift = {regs_r.txShift[`GCSR_SHIFT_W-2:0], 1'b0};
					end
				end
			end
			gcsr_pkg::GCSR_COMMIT: begin
				// One cycle only; the port is idle again after it
				regs_nxt.state = gcsr_pkg::GCSR_IDLE;
				if (regs_r.rxShift[`GCSR_WR_BIT]) begin
					// Register write
					case (regIdx)
						`GCSR_REG_GCONF: begin
							// Locked copy stays until reset
							if (!regs_r.gconf[`GCSR_GC_LOCK]) begin
								// Reserved bits stored as written
								regs_nxt.gconf = wrData[`GCSR_GCONF_W-1:0];
							end
						end
						`GCSR_REG_TESTSEL: begin
							// Upper codes kept as written
							regs_nxt.testSel = wrData[`GCSR_TESTSEL_W-1:0];
						end
						`GCSR_REG_XCMP: begin
							// Full word lands at once, so no torn compare
							regs_nxt.compare = wrData;
						end
						default: begin
							// Read-only or unmapped: ignored
							regs_nxt.state = gcsr_pkg::GCSR_IDLE;
						end
					endcase
				end else begin
					// Read: result goes out in next frame
					// Held until the next read, not cleared by writes
					regs_nxt.readData = readMux(regIdx, regs_r, ennS);
					if (regIdx == `GCSR_REG_GLOBAL_STATUS) begin
						clrStat = 1'b1;
					end
				end
			end
			default: begin
				// Illegal code falls back to idle
				regs_nxt.state = gcsr_pkg::GCSR_IDLE;
			end
		endcase

		// Sticky status; a set in the clearing cycle wins
		// Reset flag has no set here; only reset raises it
		regs_nxt.global_status[`GCSR_GS_RESET] = stickyNext(1'b0,
			regs_r.global_status[`GCSR_GS_RESET], clrStat);
		// Active error re-sets the flag, so it cannot clear
		regs_nxt.global_status[`GCSR_GS_DRVA] = stickyNext(drvAErr,
			regs_r.global_status[`GCSR_GS_DRVA], clrStat);
		regs_nxt.global_status[`GCSR_GS_DRVB] = stickyNext(drvBErr,
			regs_r.global_status[`GCSR_GS_DRVB], clrStat);
		// Pump flag kept sticky like the driver flags
		regs_nxt.global_status[`GCSR_GS_UV] = stickyNext(pumpUndervoltage,
			regs_r.global_status[`GCSR_GS_UV], clrStat);

		// Registered outputs
		// One clk of lag on each, traded for glitch-free pins
		// Pulse is high only while position equals the compare word
		regs_nxt.pulse      = (actual_position == regs_r.compare);
		regs_nxt.intLvl     = intRequest;
		regs_nxt.dirA       = motorADirCmd ^ regs_r.gconf[`GCSR_GC_INVA];
		regs_nxt.dirB       = motorBDirCmd ^ regs_r.gconf[`GCSR_GC_INVB];
		// Gate follows the live level, not the sticky flag
		regs_nxt.drvDisable = pumpUndervoltage;
		// SDO floats outside a frame
		// Enable lags select by the sync delay
		regs_nxt.sdoOe      = ~csnS;
	end

	// State register; status reset flag comes up set
	// Edge history reset high so no false frame at release
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			regs_r         <= '0;
			regs_r.state   <= gcsr_pkg::GCSR_IDLE;
			regs_r.sckPrev <= 1'b1;
			regs_r.csnPrev <= 1'b1;
			regs_r.global_status   <= `GCSR_GLOBAL_STATUS_RST;
		end else begin
			regs_r <= regs_nxt;
		end
	end

	// Serial out, MSB first
	// Host sees status byte first, then the last read word
	assign sdoOut = regs_r.txShift[`GCSR_SHIFT_W-1];
	assign sdoOe  = regs_r.sdoOe;

	// Pulse and interrupt pins, tristated until enabled
	// Board needs pull-ups while the enable bit is low
	assign position_pulse_out = regs_r.pulse;
	assign positionPulseOe    = regs_r.gconf[`GCSR_GC_POSCMP];
	assign intOut             = regs_r.intLvl;
	assign intOe              = regs_r.gconf[`GCSR_GC_POSCMP];

	// Motor and driver controls
	// Inversion applies from the clk after the config write
	assign motorADirOut   = regs_r.dirA;
	assign motorBDirOut   = regs_r.dirB;
	assign driversDisable = regs_r.drvDisable;

	// Test routing; host keeps both zero normally
	// Analog switch itself sits outside this block
	assign refTestEnable    = regs_r.gconf[`GCSR_GC_TESTMODE];
	assign testSignalSelect = regs_r.testSel;

endmodule // gcsr_regs_top

`default_nettype wire

// ==== verification/gcsr_regs_properties.sv ====
// Concurrent checks on the pins of the register group.
// Assumes binding onto gcsr_regs_top; single clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "gcsr_cfg.svh"

module gcsr_regs_properties (
	// Clock and reset
	input  wire logic                         clk,
	input  wire logic                         rst_n,
	// Watched pins
	input  wire logic                         csnPin_n,
	input  wire logic                         sdoOe,
	input  wire logic [`GCSR_DATA_W-1:0]      actual_position,
	input  wire logic                         intRequest,
	input  wire logic                         motorADirCmd,
	input  wire logic                         motorBDirCmd,
	input  wire logic                         pumpUndervoltage,
	input  wire logic                         position_pulse_out,
	input  wire logic                         positionPulseOe,
	input  wire logic                         intOut,
	input  wire logic                         intOe,
	input  wire logic                         motorADirOut,
	input  wire logic                         motorBDirOut,
	input  wire logic                         driversDisable,
	input  wire logic                         refTestEnable,
	input  wire logic [`GCSR_TESTSEL_W-1:0]   testSignalSelect
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Select low long enough to cover the enable lag
	sequence csLow; !csnPin_n [*5]; endsequence
	// Idle port with any commit already landed
	sequence csIdle; csnPin_n [*8]; endsequence

	a_oe_pair: assert property (positionPulseOe == intOe)
		else $error("pulse and interrupt enables differ");
	a_int_follow: assert property ($past(rst_n) |-> intOut == $past(intRequest))
		else $error("interrupt pin lost its request");
	a_pulse_drop: assert property (position_pulse_out && $changed(actual_position) |=> !position_pulse_out)
		else $error("pulse stayed high on mismatch");
	a_dir_a: assert property (csIdle ##0 $changed(motorADirCmd) |=> $changed(motorADirOut))
		else $error("motor A direction not following");
	a_dir_b: assert property (csIdle ##0 $changed(motorBDirCmd) |=> $changed(motorBDirOut))
		else $error("motor B direction not following");
	a_pump_gate: assert property ($past(rst_n) |-> driversDisable == $past(pumpUndervoltage))
		else $error("drivers not gated by undervoltage");
	a_reset_zero: assert property (!$past(rst_n) |-> !positionPulseOe && !refTestEnable && testSignalSelect == 4'h0)
		else $error("output not zero after reset");
	a_cfg_commit: assert property ($changed(positionPulseOe) || $changed(refTestEnable) |-> csnPin_n)
		else $error("configuration changed inside a frame");
	a_sdo_drive: assert property (csLow |-> sdoOe)
		else $error("data out not driven in frame");
endmodule // gcsr_regs_properties
`default_nettype wire

// ==== verification/gcsr_host_model.sv ====
// Host side of the serial register port, mode 3 framing.
// Assumes the bench calls xfer and resolves the data-out line.
`timescale 1ns/100ps
`default_nettype none

module gcsr_host_model (
	// Bench clock
	input  wire logic clk,
	// Serial pins
	output logic      sck,
	output logic      csn_n,
	output logic      sdi,
	input  wire logic sdo
);
	// Link clock stands high, select released
	initial begin
		sck = 1'b1;
		csn_n = 1'b1;
		sdi = 1'b0;
	end

	// One whole 40-bit access, MSB first, half period of 4 clk
	task automatic xfer(input logic [39:0] tx, output logic [39:0] rx);
		@(negedge clk);
		csn_n = 1'b0;
		repeat (4) @(negedge clk);
		for (int i = 39; i >= 0; i--) begin
			sck = 1'b0;
			sdi = tx[i];
			repeat (4) @(negedge clk);
			rx[i] = sdo;
			sck = 1'b1;
			repeat (4) @(negedge clk);
		end
		csn_n = 1'b1;
		// Released data shows the inverse, not a stale bit
		sdi = ~sdi;
		// Long idle so the commit lands before the next step
		repeat (10) @(negedge clk);
	endtask
endmodule // gcsr_host_model
`default_nettype wire

// ==== verification/gcsr_regs_top_tb_top.sv ====
// Self-checking bench for the global configuration and status registers.
// Assumes the host model frames accesses; a model here predicts each answer.
`timescale 1ns/100ps
`default_nettype none
`include "gcsr_cfg.svh"

module gcsr_regs_top_tb_top;
	localparam logic [7:0] REV = 8'h3C; // Revision code, value arbitrary
	// Pins
	logic        clk, rst_n, sck, csn_n, sdi, sdoOut, sdoOe, sdoLast, enn, intReq, dirA, dirB;
	logic        aOt, aSh, bOt, bSh, uv, pulse, pulseOe, intOut, intOe, dirAOut, dirBOut, drvDis, refTe;
	logic [31:0] pos;
	logic [3:0]  sel;
	// Model state and counters
	int          mismatches, cmp_count, cyc;
	logic [10:0] mCfg;
	logic [3:0]  mSt, mSel;
	logic [31:0] mRd;
	// Floating data line shows the inverse of its last value
	wire         sdoLine = sdoOe ? sdoOut : ~sdoLast;

	gcsr_regs_top #(.REVISION_CODE(REV)) DUT (.clk, .rst_n, .sckPin(sck), .csnPin_n(csn_n), .sdiPin(sdi),
		.sdoOut, .sdoOe, .driver_enable_n_pin(enn), .actual_position(pos), .intRequest(intReq),
		.motorADirCmd(dirA), .motorBDirCmd(dirB), .driverAOverTemp(aOt), .driverAShort(aSh),
		.driverBOverTemp(bOt), .driverBShort(bSh), .pumpUndervoltage(uv), .position_pulse_out(pulse),
		.positionPulseOe(pulseOe), .intOut, .intOe, .motorADirOut(dirAOut), .motorBDirOut(dirBOut),
		.driversDisable(drvDis), .refTestEnable(refTe), .testSignalSelect(sel));
	gcsr_host_model HOST (.clk, .sck, .csn_n, .sdi, .sdo(sdoLine));

	// Clock, 50 ns
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Last driven data bit, and the hang guard
	always @(posedge clk) begin
		if (!rst_n) sdoLast <= 1'b0;
		else if (sdoOe) sdoLast <= sdoOut;
		cyc++;
		if (cyc > 30000) begin
			mismatches++;
			summarize();
		end
	end

	// Compare one value against the model
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One access; the answer belongs to the previous read
	task automatic acc(input logic wr, input logic [6:0] idx, input logic [31:0] data);
		logic [39:0] rx;
		HOST.xfer({wr, idx, data}, rx);
		chk(rx[31:0], mRd);
		chk(32'(rx[39:32]), 32'(mSt));
		if (wr) begin
			if (idx == 7'h00 && !mCfg[10]) mCfg = data[10:0];
			if (idx == 7'h03) mSel = data[3:0];
		end else begin
			mRd = (idx == 7'h00) ? 32'(mCfg) : (idx == 7'h01) ? 32'(mSt) :
				(idx == 7'h04) ? {REV, 16'h0, enn, 7'h0} : 32'h0;
			// Read clears only flags whose cause is gone
			if (idx == 7'h01) mSt = {uv, bOt | bSh, aOt | aSh, 1'b0};
		end
		chk(32'({pulseOe, intOe, refTe, sel}), 32'({mCfg[3], mCfg[3], mCfg[7], mSel}));
		dirA = 1'($urandom);
		dirB = 1'($urandom);
		intReq = 1'($urandom);
		repeat (2) @(negedge clk);
		chk(32'({dirAOut, dirBOut, intOut, drvDis}), 32'({dirA ^ mCfg[8], dirB ^ mCfg[9], intReq, uv}));
	endtask

	// Verdict and end of run
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// Main sequence
	initial begin
		void'($urandom(32));
		{rst_n, intReq, dirA, dirB, aOt, aSh, bOt, bSh, uv} = '0;
		pos = '0;
		enn = 1'($urandom);
		for (int r = 0; r < 2; r++) begin
			// Reset model to documented values
			mCfg = '0;
			mSel = '0;
			mRd = '0;
			mSt = 4'h1;
			repeat (2) @(negedge clk);
			rst_n = 1'b1;
			repeat (4) @(negedge clk);
			acc(1'b0, 7'h01, '0);
			acc(1'b0, 7'h04, '0);
			acc(1'b0, 7'h00, '0);
			// Reserved bits written as zero
			acc(1'b1, 7'h00, 32'h0000_0388);
			for (int c = 0; c < 5; c++) acc(1'b1, 7'h03, 32'(c));
			acc(1'b1, 7'h03, '0);
			pos = $urandom;
			acc(1'b1, 7'h05, pos);
			chk(32'(pulse), 32'h1);
			pos = pos + 1;
			repeat (2) @(negedge clk);
			chk(32'(pulse), 32'h0);
			// Refused write, write-only and unmapped reads
			acc(1'b1, 7'h04, '1);
			acc(1'b0, 7'h05, '0);
			acc(1'b0, 7'h10, '0);
			// Driver A event ends, B and pump persist
			aOt = 1'b1;
			repeat (3) @(negedge clk);
			aOt = 1'b0;
			bSh = 1'b1;
			uv = 1'b1;
			repeat (3) @(negedge clk);
			mSt = mSt | 4'hE;
			acc(1'b0, 7'h01, '0);
			bSh = 1'b0;
			uv = 1'b0;
			acc(1'b0, 7'h01, '0);
			// Lock, then a write that must be ignored
			acc(1'b1, 7'h00, 32'h0000_0400);
			acc(1'b1, 7'h00, 32'h0000_0008);
			acc(1'b0, 7'h00, '0);
			enn = ~enn;
			acc(1'b0, 7'h04, '0);
			// Extra frame so the last read answer is compared
			acc(1'b0, 7'h10, '0);
			// Second reset in mid-run
			rst_n = 1'b0;
		end
		summarize();
	end
endmodule // gcsr_regs_top_tb_top

bind gcsr_regs_top gcsr_regs_properties u_props (.clk, .rst_n, .csnPin_n, .sdoOe, .actual_position,
	.intRequest, .motorADirCmd, .motorBDirCmd, .pumpUndervoltage, .position_pulse_out, .positionPulseOe,
	.intOut, .intOe, .motorADirOut, .motorBDirOut, .driversDisable, .refTestEnable, .testSignalSelect);
`default_nettype wire
